// ==== design/pgc_gpio_top.sv ====
// Eight general purpose pins: configuration bytes, pad drive, debounce,
// edge flags and the shared active-low interrupt request.
// Assumes the serial host engine turns bus cycles into byte read/write strobes
// on clk_sys, and that the alternate mode enables come from logic on clk_sys.
`timescale 1ns/10ps
module pgc_gpio_top #(
  parameter int TICK_CYCLES = pgc_pkg::PGC_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Power state
  input wire logic global_shutdown,
  input wire logic [pgc_pkg::PGC_NPINS-1:0] alternate_function_on,
  // Register access from the host engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Pins
  input wire logic [pgc_pkg::PGC_NPINS-1:0] gpio_in,
  output logic [pgc_pkg::PGC_NPINS-1:0] gpio_out_q,
  output logic [pgc_pkg::PGC_NPINS-1:0] gpio_oe_q,
  // Interrupt
  output logic interrupt_request_n_q
);
  import pgc_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [7:0] IN_LVL_MASK = 8'h04;

  // Time base
  logic [TW-1:0] div_q;
  logic tick_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == TICK_LAST);
      div_q <= (div_q == TICK_LAST) ? '0 : div_q + TW'(1);
    end
  end

  // Pin synchronisers
  logic [PGC_NPINS-1:0] meta_q;
  logic [PGC_NPINS-1:0] sync_q;
  logic [1:0] valid_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      valid_q <= 2'h0;
    end else begin
      meta_q <= gpio_in;
      sync_q <= meta_q;
      valid_q <= {valid_q[0], 1'b1};
    end
  end

  // Register decode
  logic stat_hit;
  logic stat_clr;
  logic reload;

  assign stat_hit = (reg_addr == PGC_EDGE_STAT_OFS);
  assign stat_clr = reg_rd && stat_hit;
  assign reload = rst || global_shutdown;

  logic [7:0] cfg_q [PGC_NPINS];
  logic [7:0] rd_term [PGC_NPINS];
  logic [PGC_NPINS-1:0] level;
  logic [PGC_NPINS-1:0] edge_hit;
  logic [PGC_NPINS-1:0] flag_q;
  logic [PGC_NPINS-1:0] flag_d;
  logic [PGC_NPINS-1:0] drv_out;
  logic [PGC_NPINS-1:0] drv_oe;

  genvar gi;
  generate
    for (gi = 0; gi < PGC_NPINS; gi++) begin : g_pin
      logic hit;
      logic is_out;
      logic is_in;
      logic rise;
      logic fall;
      logic [1:0] dbnc_sel;
      logic [1:0] edge_sel;

      assign hit = (reg_addr == PGC_PIN_CFG_OFS[gi]);
      assign is_out = !alternate_function_on[gi] && !cfg_q[gi][PGC_DIR_BIT];
      assign is_in = !alternate_function_on[gi] && cfg_q[gi][PGC_DIR_BIT];
      // Output pins run no filter timing at all
      assign dbnc_sel = is_in ? cfg_q[gi][PGC_DBNC_LO +: 2] : PGC_DBNC_NONE;
      assign edge_sel = cfg_q[gi][PGC_EDGE_LO +: 2];

      always_ff @(posedge clk_sys) begin
        if (reload) begin
          cfg_q[gi] <= alternate_function_on[gi] ? PGC_RST_ALT[gi] : PGC_RST_NORMAL[gi];
        end else if (reg_wr && hit) begin
          // Level bit is never stored; reads show the debounced pin level
          cfg_q[gi] <= reg_wdata & ~IN_LVL_MASK;
        end
      end

      pgc_pin_filt u_filt (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick_q),
        .start(valid_q[1]),
        .sel(dbnc_sel),
        .raw(sync_q[gi]),
        .level_q(level[gi]),
        .rise_q(rise),
        .fall_q(fall)
      );

      // Debounced edges only, and only while an input
      assign edge_hit[gi] = is_in && ((rise && edge_sel[PGC_EDGE_RISE_BIT]) ||
                                      (fall && edge_sel[PGC_EDGE_FALL_BIT]));

      // Open-drain drives low only; push-pull drives both levels
      assign drv_oe[gi] = is_out && (cfg_q[gi][PGC_DRV_BIT] || !cfg_q[gi][PGC_OUT_LVL_BIT]);
      assign drv_out[gi] = is_out && cfg_q[gi][PGC_DRV_BIT] && cfg_q[gi][PGC_OUT_LVL_BIT];

      // On outputs the level bit still shows the pad, with no promise
      assign rd_term[gi] = hit ? {cfg_q[gi][7:3], level[gi], cfg_q[gi][1:0]} : 8'h00;
    end
  endgenerate

  // Set wins over a clear-on-read in the same cycle
  assign flag_d = edge_hit | (flag_q & ~{PGC_NPINS{stat_clr}});

  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = stat_hit ? flag_q : 8'h00;
    for (int i = 0; i < PGC_NPINS; i++) begin
      rd_mux = rd_mux | rd_term[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_q <= '0;
      interrupt_request_n_q <= 1'b1;
      reg_rdata_q <= 8'h00;
      gpio_out_q <= '0;
      gpio_oe_q <= '0;
    end else begin
      flag_q <= flag_d;
      interrupt_request_n_q <= ~(|flag_d);
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
      gpio_out_q <= drv_out;
      gpio_oe_q <= drv_oe;
    end
  end
endmodule // pgc_gpio_top

// ==== inc/pgc_pkg.sv ====
// Constants shared by the general purpose pin configuration block.
// Assumes a 50 MHz system clock and byte-wide register access.
package pgc_pkg;

  localparam int PGC_NPINS = 8;

  // Register offsets, one per pin, plus the edge flag register
  localparam logic [7:0] PGC_PIN_CFG_OFS [PGC_NPINS] = '{
    8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d};
  localparam logic [7:0] PGC_EDGE_STAT_OFS = 8'h0b;

  // Field positions in a pin configuration byte
  localparam int PGC_DBNC_LO = 6;
  localparam int PGC_EDGE_LO = 4;
  localparam int PGC_OUT_LVL_BIT = 3;
  localparam int PGC_IN_LVL_BIT = 2;
  localparam int PGC_DIR_BIT = 1;
  localparam int PGC_DRV_BIT = 0;

  // Debounce selection codes and their times in milliseconds
  localparam logic [1:0] PGC_DBNC_NONE = 2'h0;
  localparam logic [1:0] PGC_DBNC_8 = 2'h1;
  localparam logic [1:0] PGC_DBNC_16 = 2'h2;
  localparam logic [5:0] PGC_DBNC_8_MS = 6'h08;
  localparam logic [5:0] PGC_DBNC_16_MS = 6'h10;
  localparam logic [5:0] PGC_DBNC_32_MS = 6'h20;

  // Edge interrupt selection bits: bit 0 falling, bit 1 rising
  localparam int PGC_EDGE_FALL_BIT = 0;
  localparam int PGC_EDGE_RISE_BIT = 1;

  // Shutdown reload values, normal and alternate mode
  localparam logic [7:0] PGC_RST_NORMAL [PGC_NPINS] = '{
    8'h02, 8'h02, 8'h02, 8'h02, 8'h03, 8'h02, 8'h02, 8'h02};
  localparam logic [7:0] PGC_RST_ALT [PGC_NPINS] = '{
    8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h02, 8'h00};

  // Debounce time base
  localparam int PGC_CLK_HZ = 50_000_000;
  localparam int PGC_TICK_MS = 1;
  localparam int PGC_TICK_CYC = PGC_CLK_HZ / 1000 * PGC_TICK_MS;

endpackage

// ==== design/pgc_pin_filt.sv ====
// One pin's debounce filter and edge detector.
// Assumes raw is already synchronised and tick is a one-cycle 1 ms enable.
`timescale 1ns/10ps
module pgc_pin_filt (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Time base and selection
  input wire logic tick,
  input wire logic start,
  input wire logic [1:0] sel,
  // Sampled pin and results
  input wire logic raw,
  output logic level_q,
  output logic rise_q,
  output logic fall_q
);
  import pgc_pkg::*;

  logic [5:0] cnt_q;
  logic primed_q;
  logic [5:0] need_ms;
  logic differ;
  logic done;

  assign need_ms = (sel == PGC_DBNC_8) ? PGC_DBNC_8_MS :
                   (sel == PGC_DBNC_16) ? PGC_DBNC_16_MS : PGC_DBNC_32_MS;
  assign differ = primed_q && (raw != level_q);
  // One extra tick so the level has held for at least the full time
  assign done = (sel == PGC_DBNC_NONE) || (tick && (cnt_q == need_ms));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      cnt_q <= 6'h00;
      primed_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (!primed_q) begin
        // First valid sample taken silently, no false edge after reset
        if (start) begin
          level_q <= raw;
          primed_q <= 1'b1;
        end
      end else if (!differ) begin
        cnt_q <= 6'h00;
      end else if (done) begin
        level_q <= raw;
        rise_q <= raw;
        fall_q <= ~raw;
        cnt_q <= 6'h00;
      end else if (tick) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end
endmodule // pgc_pin_filt

// ==== dv/pgc_gpio_sva.sv ====
// Port checks for pgc_gpio_top.
// Bound into the block; sees only its ports.
`timescale 1ns/10ps
module pgc_gpio_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic global_shutdown,
  input wire logic [7:0] alternate_function_on,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [7:0] gpio_in,
  input wire logic [7:0] gpio_out_q,
  input wire logic [7:0] gpio_oe_q,
  input wire logic interrupt_request_n_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rd_flags = reg_rd && reg_addr == 8'h0b;
  wire unmapped = (reg_addr < 8'h36 || reg_addr > 8'h3d) && reg_addr != 8'h0b;
  // A reload or second write would hide the first write's effect
  sequence pin0_wr;
    reg_wr && reg_addr == 8'h36 && !global_shutdown && !alternate_function_on[0];
  endsequence
  sequence quiet;
    !reg_wr && !global_shutdown && !alternate_function_on[0];
  endsequence
  rst_vals_a: assert property ($past(rst) |->
    !reg_rdata_q && !gpio_oe_q && !gpio_out_q && interrupt_request_n_q) else $error("reset values wrong");
  od_rel_a: assert property ((gpio_out_q & ~gpio_oe_q) == 8'h00)
    else $error("high level on released pin");
  pin0_drv_a: assert property (pin0_wr ##1 quiet |=>
    gpio_oe_q[0] == (!$past(reg_wdata[1], 2) && ($past(reg_wdata[0], 2) || !$past(reg_wdata[3], 2)))
    && gpio_out_q[0] == (!$past(reg_wdata[1], 2) && $past(reg_wdata[0], 2) && $past(reg_wdata[3], 2)))
    else $error("pin 0 drive wrong");
  irq_hold_a: assert property (!interrupt_request_n_q && !rd_flags && !$past(rd_flags) |=>
    !interrupt_request_n_q) else $error("interrupt dropped unread");
  irq_clr_a: assert property ($rose(interrupt_request_n_q) && !$past(rst) |->
    $past(rd_flags) || $past(rd_flags, 2)) else $error("interrupt released unread");
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
  unmap_rd_a: assert property (reg_rd && unmapped |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  reload_a: assert property (global_shutdown ##1 reg_rd && reg_addr == 8'h3a |=>
    (reg_rdata_q & 8'hfb) == ($past(alternate_function_on[4], 2) ? 8'h01 : 8'h03))
    else $error("pin 4 reload wrong");
endmodule // pgc_gpio_sva

bind pgc_gpio_top pgc_gpio_sva #(.TICK_CYCLES(TICK_CYCLES)) i_pgc_gpio_sva (.*);

// ==== dv/pgc_pin_model.sv ====
// Circuits on the eight pads, levels set by the bench.
// A driven pad follows the block; a released one its pull level.
`timescale 1ns/10ps
module pgc_pin_model (
  input wire logic [7:0] gpio_out_q,
  input wire logic [7:0] gpio_oe_q,
  input wire logic [7:0] ext,
  output logic [7:0] gpio_in
);
  assign gpio_in = (gpio_oe_q & gpio_out_q) | (~gpio_oe_q & ext);
endmodule // pgc_pin_model

// ==== dv/pgc_gpio_tb_top.sv ====
// Bench for pgc_gpio_top: byte model of the pin configuration,
// compared at every rcfg read and every write. Pads from pgc_pin_model.
`timescale 1ns/10ps
module pgc_gpio_tb_top;
  import pgc_pkg::*;
  localparam int TK = 4;
  logic clk_sys = 0, rst = 1, global_shutdown = 0, reg_wr = 0, reg_rd = 0, interrupt_request_n_q;
  logic [7:0] alternate_function_on = 0, reg_addr = 0, reg_wdata = 0, ext = 0, rdat;
  logic [7:0] reg_rdata_q, gpio_in, gpio_out_q, gpio_oe_q;
  logic [7:0] cfg [8];
  int failures = 0, num_checks = 0, k;
  always #10 clk_sys = ~clk_sys;
  pgc_gpio_top #(.TICK_CYCLES(TK)) i_pgc_gpio_top (.*);
  pgc_pin_model i_pgc_pin_model (.gpio_out_q(gpio_out_q), .gpio_oe_q(gpio_oe_q), .ext(ext), .gpio_in(gpio_in));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [7:0] drv(bit o);
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
      v[i] = !alternate_function_on[i] && !cfg[i][1] && (o ? cfg[i][0] && cfg[i][3] : cfg[i][0] || !cfg[i][3]);
    return v;
  endfunction
  task automatic rd(logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1;
    cyc(1);
    reg_rd <= 0;
    cyc(1);
    rdat = reg_rdata_q;
  endtask
  task automatic wr(int p, logic [7:0] d);
    reg_addr <= PGC_PIN_CFG_OFS[p];
    reg_wdata <= d;
    reg_wr <= 1;
    cyc(1);
    reg_wr <= 0;
    cyc(3);
    cfg[p] = d;
    chk("oe", gpio_oe_q, drv(0));
    chk("out", gpio_out_q, drv(1));
  endtask
  // Level bit only has meaning on input pins
  task automatic rcfg(int p);
    logic [7:0] m;
    m = cfg[p][1] ? 8'hff : 8'hfb;
    rd(PGC_PIN_CFG_OFS[p]);
    chk("cfg", rdat & m, ((cfg[p] & 8'hfb) | {ext[p], 2'b00}) & m);
  endtask
  task automatic shut(logic [7:0] a);
    alternate_function_on <= a;
    global_shutdown <= 1;
    cyc(1);
    global_shutdown <= 0;
    rd(8'h3a);
    cyc(300);
    for (int p = 0; p < 8; p++) begin
      cfg[p] = a[p] ? PGC_RST_ALT[p] : PGC_RST_NORMAL[p];
      rcfg(p);
    end
    chk("oe", gpio_oe_q, drv(0));
  endtask
  initial begin
    cyc(100000);
    failures++;
    conclude();
  end
  initial begin
    k = $urandom(47);
    cyc(20);
    rst <= 0;
    ext <= 8'($urandom);
    shut(8'h00);
    shut(8'($urandom));
    for (int p = 0; p < 8; p++) wr(p, 8'($urandom));
    cyc(300);
    for (int p = 0; p < 8; p++) rcfg(p);
    shut(8'h00);
    rd(8'h40);
    chk("unmapped", rdat, 8'h00);
    for (int s = 1; s < 4; s++) begin
      k = 8 << (s - 1);
      wr(0, {s[1:0], 6'h02});
      ext[0] <= ~ext[0];
      cyc(k * TK - 6);
      ext[0] <= ~ext[0];
      cyc(k * TK + 20);
      rcfg(0);
      ext[0] <= ~ext[0];
      cyc(k * TK + TK + 10);
      rcfg(0);
    end
    rd(8'h0b);
    for (int c = 0; c < 4; c++) begin
      k = $urandom_range(7);
      wr(k, {2'b00, c[1:0], 4'b0010});
      ext[k] <= ~ext[k];
      cyc(10);
      ext[k] <= ~ext[k];
      cyc(10);
      chk("irq", interrupt_request_n_q, 8'(c == 0));
      rd(8'h0b);
      chk("flags", rdat, 8'(c != 0) << k);
      cyc(2);
      chk("irq", interrupt_request_n_q, 8'h01);
    end
    wr(3, 8'hf1);
    wr(3, 8'hf9);
    wr(3, 8'hf1);
    cyc(10);
    rd(8'h0b);
    chk("flags", rdat, 8'h00);
    conclude();
  end
endmodule // pgc_gpio_tb_top
